// >>> include/mcgs_regs.svh
// register offsets, field positions and reset values of the module clock control block
`ifndef MCGS_REGS_SVH
`define MCGS_REGS_SVH
`define MCGS_ADDR_W 32
`define MCGS_OFS_CLK_EN 32'hfff7f040
`define MCGS_OFS_RX_MUX 32'hfff7f048
`define MCGS_OFS_SLOW_SEL 32'hfff7f050
`define MCGS_OFS_RTC_PIN 32'hfff7f054
`define MCGS_CLK_EN_W 23
`define MCGS_CLK_EN_RST 23'h7fffff
`define MCGS_RX_MUX_W 2
`define MCGS_RX_MUX_RST 2'h0
`define MCGS_SLOW_W 2
`define MCGS_SLOW_RST 2'h0
`define MCGS_SLOW_LSB 2
`define MCGS_BIT_DTC 22
`define MCGS_BIT_RTC 20
`define MCGS_BIT_I2C 19
`define MCGS_BIT_SPI 18
`define MCGS_BIT_PCM 17
`define MCGS_BIT_CPCC 16
`define MCGS_BIT_FILT0 13
`define MCGS_BIT_FE0 10
`define MCGS_BIT_PWM0 6
`define MCGS_BIT_SER0 4
`define MCGS_BIT_CONV 3
`define MCGS_BIT_PMB 2
`define MCGS_BIT_GIO 1
`define MCGS_BIT_TMR 0
`define MCGS_RX1_BIT 1
`define MCGS_RX0_BIT 0
`define MCGS_WD_BIT 1
`define MCGS_RTC_BIT 0
`define MCGS_SWITCH_MAX 60
`endif

// >>> include/mcgs_pkg.sv
// types of the module clock control block
package mcgs_pkg;
	typedef logic [31:0] mcgs_word_t;
	typedef logic [31:0] mcgs_addr_t;
endpackage

// >>> hw/mcgs_ctrl.sv
// module clock gating, receive input cross mux and slow clock source select
`include "mcgs_regs.svh"
module mcgs_ctrl #(
	parameter int NUM_GATES = `MCGS_CLK_EN_W
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire mcgs_pkg::mcgs_addr_t addr_i,
	input wire mcgs_pkg::mcgs_word_t wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output mcgs_pkg::mcgs_word_t rdata_o,
	input wire logic [NUM_GATES-1:0] module_clk_i,
	output logic [NUM_GATES-1:0] module_clk_o,
	output logic [NUM_GATES-1:0] clk_gate_o,
	input wire logic serial_zero_rx_pin_i,
	input wire logic serial_one_rx_pin_i,
	output logic receiver_zero_rx_o,
	output logic receiver_one_rx_o,
	input wire logic low_freq_oscillator_i,
	input wire logic crystal_clock_input_i,
	input wire logic test_clock_pin_i,
	output logic watchdog_clk_o,
	output logic realtime_clk_o
);
	import mcgs_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// register file

	logic [NUM_GATES-1:0] clk_en_q;
	logic [`MCGS_RX_MUX_W-1:0] rx_mux_q;
	logic [`MCGS_SLOW_W-1:0] slow_sel_q;
	logic rtc_pin_sel_q;
	mcgs_word_t rdata_q;

	function automatic logic hit(input mcgs_addr_t a, input mcgs_addr_t ofs);
		hit = (a == ofs);
	endfunction

	// reserved bit 21 is stored too: it is read/write and resets to one
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			clk_en_q <= NUM_GATES'(`MCGS_CLK_EN_RST);
		else if (wr_i && hit(addr_i, `MCGS_OFS_CLK_EN))
			clk_en_q <= wdata_i[NUM_GATES-1:0];
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			rx_mux_q <= `MCGS_RX_MUX_RST;
		else if (wr_i && hit(addr_i, `MCGS_OFS_RX_MUX))
			rx_mux_q <= wdata_i[`MCGS_RX_MUX_W-1:0];
	end

	// bits 1..0 of the select register are reserved and read zero
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			slow_sel_q <= `MCGS_SLOW_RST;
		else if (wr_i && hit(addr_i, `MCGS_OFS_SLOW_SEL))
			slow_sel_q <= wdata_i[`MCGS_SLOW_LSB+`MCGS_SLOW_W-1:`MCGS_SLOW_LSB];
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			rtc_pin_sel_q <= 1'b0;
		else if (wr_i && hit(addr_i, `MCGS_OFS_RTC_PIN))
			rtc_pin_sel_q <= wdata_i[0];
	end

	// unmapped addresses read zero
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			rdata_q <= 32'h0;
		else if (!rd_i)
			rdata_q <= 32'h0;
		else if (hit(addr_i, `MCGS_OFS_CLK_EN))
			rdata_q <= 32'(clk_en_q);
		else if (hit(addr_i, `MCGS_OFS_RX_MUX))
			rdata_q <= 32'(rx_mux_q);
		else if (hit(addr_i, `MCGS_OFS_SLOW_SEL))
			rdata_q <= 32'({slow_sel_q, 2'h0});
		else if (hit(addr_i, `MCGS_OFS_RTC_PIN))
			rdata_q <= 32'(rtc_pin_sel_q);
		else
			rdata_q <= 32'h0;
	end
	assign rdata_o = rdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// glitch-free module clock gates
	// enable is retimed on the falling edge of each module clock, so outside reset it
	// only changes while that clock is low and no runt can reach the gated clock

	assign clk_gate_o = clk_en_q;

	genvar g;
	generate
		for (g = 0; g < NUM_GATES; g++)
		begin : gen_gate
			logic en_lat_q;
			always_ff @(negedge module_clk_i[g] or posedge rst_i)
			begin
				if (rst_i)
					en_lat_q <= 1'b1;
				else
					en_lat_q <= clk_en_q[g];
			end
			assign module_clk_o[g] = module_clk_i[g] & en_lat_q;
			// sampled in the high phase: the enable seen at the last falling edge rules it
			AST_GATE_APPLY: assert property (@(negedge module_clk_i[g]) disable iff (rst_i)
				1'b1 |=> module_clk_o[g] == $past(clk_en_q[g]))
				else $error("gated clock ignores its enable");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// receive input cross mux

	assign receiver_one_rx_o = rx_mux_q[`MCGS_RX1_BIT] ? serial_zero_rx_pin_i
		: serial_one_rx_pin_i;
	assign receiver_zero_rx_o = rx_mux_q[`MCGS_RX0_BIT] ? serial_one_rx_pin_i
		: serial_zero_rx_pin_i;

	////////////////////////////////////////////////////////////////////////////////
	// slow clock selection
	// a plain mux here could glitch; the sources are slow and free running,
	// so each output uses a two-leg break-before-make switch

	logic rtc_ext_clk;
	assign rtc_ext_clk = rtc_pin_sel_q ? test_clock_pin_i : crystal_clock_input_i;

	logic wd_a1_q, wd_a2_q, wd_b1_q, wd_b2_q;
	always_ff @(posedge low_freq_oscillator_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wd_a1_q <= 1'b0;
			wd_a2_q <= 1'b0;
		end
		else
		begin
			wd_a1_q <= !slow_sel_q[`MCGS_WD_BIT] && !wd_b2_q;
			wd_a2_q <= wd_a1_q;
		end
	end
	always_ff @(posedge crystal_clock_input_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wd_b1_q <= 1'b0;
			wd_b2_q <= 1'b0;
		end
		else
		begin
			wd_b1_q <= slow_sel_q[`MCGS_WD_BIT] && !wd_a2_q;
			wd_b2_q <= wd_b1_q;
		end
	end
	assign watchdog_clk_o = (low_freq_oscillator_i & wd_a2_q)
		| (crystal_clock_input_i & wd_b2_q);

	logic rt_a1_q, rt_a2_q, rt_b1_q, rt_b2_q;
	always_ff @(posedge rtc_ext_clk or posedge rst_i)
	begin
		if (rst_i)
		begin
			rt_a1_q <= 1'b0;
			rt_a2_q <= 1'b0;
		end
		else
		begin
			rt_a1_q <= !slow_sel_q[`MCGS_RTC_BIT] && !rt_b2_q;
			rt_a2_q <= rt_a1_q;
		end
	end
	always_ff @(posedge low_freq_oscillator_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rt_b1_q <= 1'b0;
			rt_b2_q <= 1'b0;
		end
		else
		begin
			rt_b1_q <= slow_sel_q[`MCGS_RTC_BIT] && !rt_a2_q;
			rt_b2_q <= rt_b1_q;
		end
	end
	assign realtime_clk_o = (rtc_ext_clk & rt_a2_q)
		| (low_freq_oscillator_i & rt_b2_q);

	////////////////////////////////////////////////////////////////////////////////
	// checks

	AST_WRITE_GATES: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_i && addr_i == `MCGS_OFS_CLK_EN |=> clk_en_q == $past(wdata_i[NUM_GATES-1:0]))
		else $error("gate enable write lost");
	AST_GATES_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		!(wr_i && addr_i == `MCGS_OFS_CLK_EN) |=> $stable(clk_en_q))
		else $error("gate enables changed without write");
	sequence s_rd_gates;
		rd_i && addr_i == `MCGS_OFS_CLK_EN;
	endsequence
	AST_READ_GATES: assert property (@(posedge clk_i) disable iff (rst_i)
		s_rd_gates |=> rdata_o == 32'($past(clk_en_q)))
		else $error("gate enable readback wrong");
	AST_RX_MUX_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_i && addr_i == `MCGS_OFS_RX_MUX |=> rx_mux_q == $past(wdata_i[1:0]))
		else $error("rx mux write lost");
	AST_RX1_PATH: assert property (@(posedge clk_i) disable iff (rst_i)
		receiver_one_rx_o == (rx_mux_q[1] ? serial_zero_rx_pin_i : serial_one_rx_pin_i))
		else $error("receiver one source wrong");
	AST_RX0_PATH: assert property (@(posedge clk_i) disable iff (rst_i)
		receiver_zero_rx_o == (rx_mux_q[0] ? serial_one_rx_pin_i : serial_zero_rx_pin_i))
		else $error("receiver zero source wrong");
	AST_SLOW_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_i && addr_i == `MCGS_OFS_SLOW_SEL |=> slow_sel_q == $past(wdata_i[3:2]))
		else $error("clock select write lost");
	AST_SLOW_READ: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && addr_i == `MCGS_OFS_SLOW_SEL |=> rdata_o[1:0] == 2'h0
		&& rdata_o[3:2] == $past(slow_sel_q))
		else $error("clock select readback wrong");
	AST_NO_DOUBLE_LEG: assert property (@(posedge clk_i) disable iff (rst_i)
		!(wd_a2_q && wd_b2_q) && !(rt_a2_q && rt_b2_q))
		else $error("two clock sources enabled at once");
	AST_IDLE_READ_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
		!rd_i |=> rdata_o == 32'h0)
		else $error("read data outside read slot");

	////////////////////////////////////////////////////////////////////////////////
	// reset state: every gate on, own receive pins, slow oscillator and external rtc source

	AST_RESET_STATE: assert property (@(posedge clk_i)
		rst_i |=> clk_en_q == NUM_GATES'(`MCGS_CLK_EN_RST) && rx_mux_q == `MCGS_RX_MUX_RST
		&& slow_sel_q == `MCGS_SLOW_RST && !rtc_pin_sel_q && rdata_o == 32'h0)
		else $error("reset state wrong");

	////////////////////////////////////////////////////////////////////////////////
	// one check per named gate bit, so a swapped field position shows up by name

	sequence s_wr_gates;
		wr_i && hit(addr_i, `MCGS_OFS_CLK_EN);
	endsequence

	AST_GATE_DTC: assert property (@(posedge clk_i) disable iff (rst_i)
		s_wr_gates |=>
		clk_gate_o[`MCGS_BIT_DTC] == $past(wdata_i[`MCGS_BIT_DTC]))
		else $error("dead-time gate bit wrong");
	AST_GATE_RTC: assert property (@(posedge clk_i) disable iff (rst_i)
		s_wr_gates |=>
		clk_gate_o[`MCGS_BIT_RTC] == $past(wdata_i[`MCGS_BIT_RTC]))
		else $error("real time clock gate bit wrong");
	AST_GATE_I2C: assert property (@(posedge clk_i) disable iff (rst_i)
		s_wr_gates |=>
		clk_gate_o[`MCGS_BIT_I2C] == $past(wdata_i[`MCGS_BIT_I2C]))
		else $error("i2c gate bit wrong");
	AST_GATE_SPI: assert property (@(posedge clk_i) disable iff (rst_i)
		s_wr_gates |=>
		clk_gate_o[`MCGS_BIT_SPI] == $past(wdata_i[`MCGS_BIT_SPI]))
		else $error("spi gate bit wrong");
	AST_GATE_PCM: assert property (@(posedge clk_i) disable iff (rst_i)
		s_wr_gates |=>
		clk_gate_o[`MCGS_BIT_PCM] == $past(wdata_i[`MCGS_BIT_PCM]))
		else $error("peak current gate bit wrong");
	AST_GATE_CPCC: assert property (@(posedge clk_i) disable iff (rst_i)
		s_wr_gates |=>
		clk_gate_o[`MCGS_BIT_CPCC] == $past(wdata_i[`MCGS_BIT_CPCC]))
		else $error("constant power gate bit wrong");
	AST_GATE_FILT0: assert property (@(posedge clk_i) disable iff (rst_i)
		s_wr_gates |=>
		clk_gate_o[`MCGS_BIT_FILT0] == $past(wdata_i[`MCGS_BIT_FILT0]))
		else $error("filter gate bit wrong");
	AST_GATE_FE0: assert property (@(posedge clk_i) disable iff (rst_i)
		s_wr_gates |=>
		clk_gate_o[`MCGS_BIT_FE0] == $past(wdata_i[`MCGS_BIT_FE0]))
		else $error("front-end gate bit wrong");
	AST_GATE_PWM0: assert property (@(posedge clk_i) disable iff (rst_i)
		s_wr_gates |=>
		clk_gate_o[`MCGS_BIT_PWM0] == $past(wdata_i[`MCGS_BIT_PWM0]))
		else $error("pwm zero gate bit wrong");
	AST_GATE_SER0: assert property (@(posedge clk_i) disable iff (rst_i)
		s_wr_gates |=>
		clk_gate_o[`MCGS_BIT_SER0] == $past(wdata_i[`MCGS_BIT_SER0]))
		else $error("serial gate bit wrong");
	AST_GATE_CONV: assert property (@(posedge clk_i) disable iff (rst_i)
		s_wr_gates |=>
		clk_gate_o[`MCGS_BIT_CONV] == $past(wdata_i[`MCGS_BIT_CONV]))
		else $error("converter gate bit wrong");
	AST_GATE_PMB: assert property (@(posedge clk_i) disable iff (rst_i)
		s_wr_gates |=>
		clk_gate_o[`MCGS_BIT_PMB] == $past(wdata_i[`MCGS_BIT_PMB]))
		else $error("power bus gate bit wrong");
	AST_GATE_GIO: assert property (@(posedge clk_i) disable iff (rst_i)
		s_wr_gates |=>
		clk_gate_o[`MCGS_BIT_GIO] == $past(wdata_i[`MCGS_BIT_GIO]))
		else $error("general io gate bit wrong");
	AST_GATE_TMR: assert property (@(posedge clk_i) disable iff (rst_i)
		s_wr_gates |=>
		clk_gate_o[`MCGS_BIT_TMR] == $past(wdata_i[`MCGS_BIT_TMR]))
		else $error("timer gate bit wrong");

	////////////////////////////////////////////////////////////////////////////////
	// remaining register paths

	AST_RX_MUX_READ: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && hit(addr_i, `MCGS_OFS_RX_MUX) |=> rdata_o == 32'($past(rx_mux_q)))
		else $error("rx mux readback wrong");
	AST_RTC_PIN_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_i && hit(addr_i, `MCGS_OFS_RTC_PIN) |=> rtc_pin_sel_q == $past(wdata_i[0]))
		else $error("rtc pin select write lost");
	AST_RTC_PIN_READ: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && hit(addr_i, `MCGS_OFS_RTC_PIN) |=> rdata_o == 32'($past(rtc_pin_sel_q)))
		else $error("rtc pin select readback wrong");
	AST_UNMAPPED_READ: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && !hit(addr_i, `MCGS_OFS_CLK_EN) && !hit(addr_i, `MCGS_OFS_RX_MUX)
		&& !hit(addr_i, `MCGS_OFS_SLOW_SEL) && !hit(addr_i, `MCGS_OFS_RTC_PIN)
		|=> rdata_o == 32'h0)
		else $error("unmapped read not zero");

	////////////////////////////////////////////////////////////////////////////////
	// clock switches: the new leg must come up in bounded time after a select change
	// the bound assumes sources no slower than a few hundred ns; slower ones need more

	localparam int SWITCH_MAX = `MCGS_SWITCH_MAX;

	sequence s_wd_to_xtal;
		$rose(slow_sel_q[`MCGS_WD_BIT]);
	endsequence
	sequence s_wd_to_slow;
		$fell(slow_sel_q[`MCGS_WD_BIT]);
	endsequence
	sequence s_rt_to_slow;
		$rose(slow_sel_q[`MCGS_RTC_BIT]);
	endsequence
	sequence s_rt_to_ext;
		$fell(slow_sel_q[`MCGS_RTC_BIT]);
	endsequence

	AST_WD_XTAL_ON: assert property (@(posedge clk_i) disable iff (rst_i)
		s_wd_to_xtal |-> ##[1:SWITCH_MAX] (wd_b2_q && !wd_a2_q))
		else $error("watchdog crystal leg not on");
	AST_WD_SLOW_ON: assert property (@(posedge clk_i) disable iff (rst_i)
		s_wd_to_slow |-> ##[1:SWITCH_MAX] (wd_a2_q && !wd_b2_q))
		else $error("watchdog slow leg not on");
	AST_RT_SLOW_ON: assert property (@(posedge clk_i) disable iff (rst_i)
		s_rt_to_slow |-> ##[1:SWITCH_MAX] (rt_b2_q && !rt_a2_q))
		else $error("rtc slow leg not on");
	AST_RT_EXT_ON: assert property (@(posedge clk_i) disable iff (rst_i)
		s_rt_to_ext |-> ##[1:SWITCH_MAX] (rt_a2_q && !rt_b2_q))
		else $error("rtc external leg not on");

endmodule // mcgs_ctrl

// >>> sim/tb_top.sv
// self-checking bench of the module clock control block
`include "mcgs_regs.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wr_i = 1'b0, rd_i = 1'b0, rd_seen = 1'b0, mclk = 1'b0;
	logic p0 = 1'b0, p1 = 1'b0, low_freq_oscillator = 1'b0, xtal = 1'b0, tck = 1'b0;
	logic [31:0] addr_i = 32'h0, wdata_i = 32'h0, lf = 32'h87c5518a, v, rdata_o, expq[$];
	logic [22:0] mod_o, gate_o;
	logic rx0_o, rx1_o, wd_o, rt_o;
	int error_cnt = 0, total_checks = 0, cyc = 0;
	always #5 clk_i = ~clk_i;
	always #7 mclk = ~mclk;
	always #30 low_freq_oscillator = ~low_freq_oscillator;
	always #45 xtal = ~xtal;
	always #55 tck = ~tck;
	mcgs_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .module_clk_i({23{mclk}}),
		.module_clk_o(mod_o), .clk_gate_o(gate_o), .serial_zero_rx_pin_i(p0),
		.serial_one_rx_pin_i(p1), .receiver_zero_rx_o(rx0_o), .receiver_one_rx_o(rx1_o),
		.low_freq_oscillator_i(low_freq_oscillator), .crystal_clock_input_i(xtal), .test_clock_pin_i(tck),
		.watchdog_clk_o(wd_o), .realtime_clk_o(rt_o));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	// expectation is queued here, the watcher below pops it when data stands
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		expq.push_back(e);
		@(posedge clk_i);
		rd_i <= 1'b0;
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_i)
	begin
		cyc++;
		if (rd_seen)
			chk(rdata_o, expq.pop_front(), "read data");
		else if (!rst_i)
			chk(rdata_o, 32'h0, "idle read data");
		rd_seen <= rd_i;
		if (cyc > 20000)
		begin
			error_cnt++;
			summarize();
		end
	end
	// a gated clock may never be high while its source is low
	always @(mod_o)
		if (!rst_i)
			chk({9'h0, mod_o & ~{23{mclk}}}, 32'h0, "gated clock runt");
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`MCGS_OFS_CLK_EN, 32'h007fffff);
		rd(`MCGS_OFS_RX_MUX, 32'h0);
		rd(`MCGS_OFS_SLOW_SEL, 32'h0);
		rd(`MCGS_OFS_RTC_PIN, 32'h0);
		wr(32'hfff7f044, 32'hffffffff);
		rd(32'hfff7f044, 32'h0);
		for (int i = 0; i < 6; i++)
		begin
			lf = nxt(lf);
			v = (i == 4) ? 32'h0 : (i == 5) ? 32'h007fffff : {9'h0, lf[22:0]};
			wr(`MCGS_OFS_CLK_EN, {lf[31:23], v[22:0]});
			rd(`MCGS_OFS_CLK_EN, v);
			chk({9'h0, gate_o}, v, "gate bits");
			repeat (2) @(negedge mclk);
			@(posedge mclk);
			#1 chk({9'h0, mod_o}, v, "gated clocks high");
			@(negedge mclk);
			#1 chk({9'h0, mod_o}, 32'h0, "gated clocks low");
		end
		// asynchronous reset in mid-run brings every gate back on
		@(posedge clk_i);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		rd(`MCGS_OFS_CLK_EN, 32'h007fffff);
		for (int s = 0; s < 16; s++)
		begin
			lf = nxt(lf);
			wr(`MCGS_OFS_RX_MUX, {lf[31:2], s[3:2]});
			p0 <= s[0];
			p1 <= s[1];
			rd(`MCGS_OFS_RX_MUX, {30'h0, s[3:2]});
			chk({30'h0, rx1_o, rx0_o},
				{30'h0, s[3] ? s[0] : s[1], s[2] ? s[1] : s[0]}, "rx mux");
		end
		// switched clocks get 600 ns to settle, the slowest source is 110 ns
		for (int k = 0; k < 8; k++)
		begin
			wr(`MCGS_OFS_RTC_PIN, {31'h0, k[2]});
			wr(`MCGS_OFS_SLOW_SEL, {28'h0, k[1:0], 2'b11});
			rd(`MCGS_OFS_SLOW_SEL, {28'h0, k[1:0], 2'b00});
			repeat (60) @(posedge clk_i);
			for (int n = 0; n < 20; n++)
			begin
				@(posedge clk_i);
				#1 chk({31'h0, wd_o}, {31'h0, k[1] ? xtal : low_freq_oscillator}, "wd clock");
				chk({31'h0, rt_o}, {31'h0, k[0] ? low_freq_oscillator : k[2] ? tck : xtal}, "rt clock");
			end
		end
		summarize();
	end
endmodule // tb_top
